// ---- hdl/scmpl_pkg.sv ----
`default_nettype none
package scmpl_pkg;

  // ==========================================================
  // Register map (byte addresses, one word each)
  localparam logic [3:0] ADDR_MODE   = 4'h0;
  localparam logic [3:0] ADDR_CFG1   = 4'h4;
  localparam logic [3:0] ADDR_CFG2   = 4'h8;
  localparam logic [3:0] ADDR_STATUS = 4'hC;

  // ==========================================================
  // Reset values
  localparam logic [2:0]  MODE_RESET = 3'h0;
  localparam logic [9:0]  CFG1_RESET = 10'h000;
  localparam logic [2:0]  CFG2_RESET = 3'h0;

  // ==========================================================
  // Clock modes
  localparam logic [2:0] CLK_MODE_0 = 3'h0;
  localparam logic [2:0] CLK_MODE_1 = 3'h1;
  localparam logic [2:0] CLK_MODE_4 = 3'h4;
  localparam logic [2:0] CLK_MODE_5 = 3'h5;
  localparam logic [2:0] CLK_MODE_6 = 3'h6;
  localparam logic [2:0] CLK_MODE_7 = 3'h7;

  // First silicon version that shares the crystal more widely
  localparam int unsigned VERSION_TWO = 2;

  // Synchroniser depth
  localparam int unsigned SYNC_STAGES = 2;

  // ==========================================================
  // Request-to-send styles in bus configuration
  typedef enum logic [1:0] {
    RTS_STYLE_MODEM = 2'h0,
    RTS_STYLE_TX    = 2'h1,
    RTS_STYLE_RX    = 2'h2,
    RTS_STYLE_OFF   = 2'h3
  } scmpl_rts_style_t;

  // ==========================================================
  // Register layouts
  typedef struct packed {
    logic idle_fill;
    logic nrzi;
    logic request_send;
  } scmpl_mode_t;

  typedef struct packed {
    logic       master_clock;
    logic       open_drain;
    logic       cd_irq_en;
    logic       cts_irq_en;
    logic       bus_config;
    logic       auto_start;
    logic       sub_b;
    logic [2:0] clock_mode;
  } scmpl_cfg1_t;

  typedef struct packed {
    scmpl_rts_style_t rts_style;
    logic             serial_output_swap;
  } scmpl_cfg2_t;

  typedef struct packed {
    logic cd_chg;
    logic cts_chg;
    logic collision;
    logic rts_pin;
    logic rx_enable;
    logic tx_enable;
    logic collision_data_in;
    logic carrier_detect_in;
    logic clear_to_send_in;
  } scmpl_status_t;

endpackage : scmpl_pkg
`default_nettype wire

// ---- hdl/scmpl_sync.sv ----
`timescale 1ns/10ps
`default_nettype none
module scmpl_sync #(
  parameter int unsigned WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Asynchronous in, synchronous out
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end

  assign sync_out = sync_r;

endmodule : scmpl_sync
`default_nettype wire

// ---- hdl/scmpl_top.sv ----
`timescale 1ns/10ps
`default_nettype none
// What this block does
// RL1: Request-send bit set drives RTS low
// RL2: Cleared bit: RTS high after transmitter done
// RL3: Bus TX style: RTS follows frame, delayed
// RL4: Bus RX style: RTS low during reception
// RL5: Bus disabled style: RTS always high
// RL6: Transmitter enabled only while CTS low
// RL7: CTS change in either direction flags interrupt
// RL8: Bus line on collision input checks bits
// RL9: Carrier detect general input or auto-start enable
// RL10: Clock mode 1: carrier detect strobes receive
// RL11: Clock mode 5: carrier detect frame sync
// RL12: Carrier detect change flags interrupt
// RL13: Transmit pin push-pull or open drain
// RL14: NRZI idle fill ORs TXD with RTS
// RL15: Swap bit moves transmit onto receive pin
// RL16: Clock modes 4,6,7 use common crystal
// RL17: Version two: also mode 0b, master clock
// RL18: Swap bit moves receive onto transmit pin
// RL19: Two-stage synchronise CTS, CD, collision inputs
// RL20: Change flags stay until status read
module scmpl_top #(
  parameter int unsigned SILICON_VERSION = 2
) (
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        SYS_RST,
  // Wishbone slave
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [3:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output var  logic [31:0] WB_DAT_O,
  output var  logic        WB_ACK_O,
  // Modem pins
  input  wire logic        CLEAR_TO_SEND_IN,
  input  wire logic        CARRIER_DETECT_IN,
  output var  logic        RTS_N_O,
  // Line pins, three signals each
  input  wire logic        TXD_PIN_I,
  output var  logic        TXD_PIN_O,
  output var  logic        TXD_PIN_OE,
  input  wire logic        RXD_PIN_I,
  output var  logic        RXD_PIN_O,
  output var  logic        RXD_PIN_OE,
  // Serial bit clock and crystal
  input  wire logic        BIT_CLK_IN,
  input  wire logic        CRYSTAL_CLOCK_IN,
  // Serial engine side
  input  wire logic        TX_BIT,
  input  wire logic        TX_BUSY,
  input  wire logic        TX_PENDING,
  input  wire logic        TX_FRAME,
  input  wire logic        TX_COLL_BIT,
  input  wire logic        RX_FRAME,
  output var  logic        RX_BIT,
  output var  logic        TX_ENABLE,
  output var  logic        RX_ENABLE,
  output var  logic        RX_STROBE,
  output var  logic        FRAME_SYNC,
  output var  logic        CD_GENERAL,
  output var  logic        COLLISION,
  output var  logic        COMMON_CLK_SEL,
  output var  logic        COMMON_CLK,
  output var  logic        EVENT_IRQ
);

  // ==========================================================
  // Input synchronisers
  localparam int unsigned NSYNC = 6;

  logic [NSYNC-1:0] sync_q;
  logic             cts_s;
  logic             cd_s;
  logic             line_s;
  logic             txd_pin_s;
  logic             rxd_pin_s;
  logic             bclk_s;
  logic             xtal_s;

  scmpl_sync #(
    .WIDTH (NSYNC)
  ) u_sync (
    .clk      (CLK),
    .rst      (SYS_RST),
    .async_in ({CRYSTAL_CLOCK_IN, BIT_CLK_IN, RXD_PIN_I, TXD_PIN_I,
                CARRIER_DETECT_IN, CLEAR_TO_SEND_IN}),
    .sync_out (sync_q)
  ); // [RL19]

  // CTS and collision data share one pin
  assign cts_s     = sync_q[0];
  assign line_s    = sync_q[0];
  assign cd_s      = sync_q[1];
  assign txd_pin_s = sync_q[2];
  assign rxd_pin_s = sync_q[3];
  assign bclk_s    = sync_q[4];
  assign xtal_s    = sync_q[5];

  // ==========================================================
  // Registers
  scmpl_pkg::scmpl_mode_t mode_r;
  scmpl_pkg::scmpl_mode_t mode_nxt;
  scmpl_pkg::scmpl_cfg1_t cfg1_r;
  scmpl_pkg::scmpl_cfg1_t cfg1_nxt;
  scmpl_pkg::scmpl_cfg2_t cfg2_r;
  scmpl_pkg::scmpl_cfg2_t cfg2_nxt;
  logic [31:0]            rdata_r;
  logic [31:0]            rdata_nxt;
  logic                   ack_r;
  logic                   ack_nxt;
  logic                   cts_chg_r;
  logic                   cts_chg_nxt;
  logic                   cd_chg_r;
  logic                   cd_chg_nxt;
  logic                   coll_flag_r;
  logic                   coll_flag_nxt;
  scmpl_pkg::scmpl_status_t status;

  logic access;
  logic wr;
  logic rd_status;

  // ==========================================================
  // Change detection and collision check
  logic cts_d_r;
  logic cd_d_r;
  logic bclk_d_r;
  logic [2:0] arm_r;
  logic cts_edge;
  logic cd_edge;
  logic bclk_rise;
  logic coll_hit;

  // No CTS or CD edges until the history holds real pin samples, not reset zeros
  assign cts_edge  = arm_r[2] & (cts_s ^ cts_d_r);
  assign cd_edge   = arm_r[2] & (cd_s ^ cd_d_r);
  assign bclk_rise = bclk_s & ~bclk_d_r;
  // Sending a one while the shared line reads zero
  assign coll_hit  = cfg1_r.bus_config & TX_FRAME & bclk_rise &
                     TX_BIT & ~line_s; // [RL8]

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      cts_d_r  <= 1'b0;
      cd_d_r   <= 1'b0;
      bclk_d_r <= 1'b0;
      arm_r    <= 3'h0;
    end else begin
      arm_r    <= {arm_r[1:0], 1'b1};
      cts_d_r  <= cts_s;
      cd_d_r   <= cd_s;
      bclk_d_r <= bclk_s;
    end
  end

  // ==========================================================
  // Wishbone slave: one wait state, ack is one cycle
  assign access    = WB_CYC_I & WB_STB_I & ~ack_r;
  assign wr        = access & WB_WE_I;
  assign rd_status = access & ~WB_WE_I &
                     (WB_ADR_I == scmpl_pkg::ADDR_STATUS);

  always_comb begin
    status = '{cd_chg:            cd_chg_r,
               cts_chg:           cts_chg_r,
               collision:         coll_flag_r,
               rts_pin:           RTS_N_O,
               rx_enable:         RX_ENABLE,
               tx_enable:         TX_ENABLE,
               collision_data_in: line_s,
               carrier_detect_in: cd_s,
               clear_to_send_in:  cts_s};
  end

  always_comb begin
    mode_nxt  = mode_r;
    cfg1_nxt  = cfg1_r;
    cfg2_nxt  = cfg2_r;
    ack_nxt   = access;
    rdata_nxt = rdata_r;
    if (wr) begin
      case (WB_ADR_I)
        scmpl_pkg::ADDR_MODE: begin
          if (WB_SEL_I[0]) begin
            mode_nxt = WB_DAT_I[2:0]; // [RL1]
          end
        end
        scmpl_pkg::ADDR_CFG1: begin
          if (WB_SEL_I[0]) begin
            cfg1_nxt[7:0] = WB_DAT_I[7:0];
          end
          if (WB_SEL_I[1]) begin
            cfg1_nxt[9:8] = WB_DAT_I[9:8];
          end
        end
        scmpl_pkg::ADDR_CFG2: begin
          if (WB_SEL_I[0]) begin
            cfg2_nxt = WB_DAT_I[2:0];
          end
        end
        default: begin
        end
      endcase
    end
    if (access & ~WB_WE_I) begin
      case (WB_ADR_I)
        scmpl_pkg::ADDR_MODE:   rdata_nxt = {29'h0000000, mode_r};
        scmpl_pkg::ADDR_CFG1:   rdata_nxt = {22'h000000, cfg1_r};
        scmpl_pkg::ADDR_CFG2:   rdata_nxt = {29'h0000000, cfg2_r};
        scmpl_pkg::ADDR_STATUS: rdata_nxt = {23'h000000, status};
        default:                rdata_nxt = 32'h00000000;
      endcase
    end
  end

  // Read clears, but a new event in the same cycle wins
  always_comb begin
    cts_chg_nxt   = cts_chg_r & ~rd_status; // [RL20]
    cd_chg_nxt    = cd_chg_r & ~rd_status; // [RL20]
    coll_flag_nxt = coll_flag_r & ~rd_status;
    if (cts_edge & cfg1_r.cts_irq_en) begin
      cts_chg_nxt = 1'b1; // [RL7]
    end
    if (cd_edge & cfg1_r.cd_irq_en) begin
      cd_chg_nxt = 1'b1; // [RL12]
    end
    if (coll_hit) begin
      coll_flag_nxt = 1'b1;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      mode_r      <= scmpl_pkg::MODE_RESET;
      cfg1_r      <= scmpl_pkg::CFG1_RESET;
      cfg2_r      <= scmpl_pkg::CFG2_RESET;
      rdata_r     <= 32'h00000000;
      ack_r       <= 1'b0;
      cts_chg_r   <= 1'b0;
      cd_chg_r    <= 1'b0;
      coll_flag_r <= 1'b0;
    end else begin
      mode_r      <= mode_nxt;
      cfg1_r      <= cfg1_nxt;
      cfg2_r      <= cfg2_nxt;
      rdata_r     <= rdata_nxt;
      ack_r       <= ack_nxt;
      cts_chg_r   <= cts_chg_nxt;
      cd_chg_r    <= cd_chg_nxt;
      coll_flag_r <= coll_flag_nxt;
    end
  end

  assign WB_DAT_O  = rdata_r;
  assign WB_ACK_O  = ack_r;
  assign EVENT_IRQ = cts_chg_r | cd_chg_r;

  // ==========================================================
  // Request-to-send in modem style
  typedef enum logic [1:0] {
    RTS_IDLE,
    RTS_ASSERT,
    RTS_DRAIN
  } scmpl_rts_state_t;

  scmpl_rts_state_t rts_st_r;
  scmpl_rts_state_t rts_st_nxt;

  always_comb begin
    rts_st_nxt = rts_st_r;
    case (rts_st_r)
      RTS_IDLE: begin
        if (mode_r.request_send) begin
          rts_st_nxt = RTS_ASSERT; // [RL1]
        end
      end
      RTS_ASSERT: begin
        if (!mode_r.request_send) begin
          rts_st_nxt = RTS_DRAIN;
        end
      end
      RTS_DRAIN: begin
        if (mode_r.request_send) begin
          rts_st_nxt = RTS_ASSERT;
        end else if (!TX_BUSY && !TX_PENDING) begin
          rts_st_nxt = RTS_IDLE; // [RL2]
        end
      end
      default: rts_st_nxt = RTS_IDLE;
    endcase
  end

  // ==========================================================
  // Bus style: frame activity delayed one bit clock
  logic bus_tx_r;
  logic bus_tx_nxt;

  always_comb begin
    bus_tx_nxt = bus_tx_r;
    if (bclk_rise) begin
      bus_tx_nxt = TX_FRAME & ~TX_COLL_BIT; // [RL3]
    end
  end

  // Pin outputs are registered
  logic rts_low;
  logic rts_n_r;
  logic rts_n_nxt;
  logic tx_val;
  logic txd_o_r;
  logic txd_o_nxt;
  logic txd_oe_r;
  logic txd_oe_nxt;
  logic rxd_o_r;
  logic rxd_o_nxt;
  logic rxd_oe_r;
  logic rxd_oe_nxt;
  logic line_o;
  logic line_oe;

  always_comb begin
    rts_low = (rts_st_r != RTS_IDLE);
    if (cfg1_r.bus_config) begin
      case (cfg2_r.rts_style)
        scmpl_pkg::RTS_STYLE_TX:  rts_low = bus_tx_r; // [RL3]
        scmpl_pkg::RTS_STYLE_RX:  rts_low = RX_FRAME; // [RL4]
        scmpl_pkg::RTS_STYLE_OFF: rts_low = 1'b0; // [RL5]
        default:                  rts_low = (rts_st_r != RTS_IDLE);
      endcase
    end
    rts_n_nxt = ~rts_low;
    tx_val    = TX_BIT;
    if (mode_r.nrzi && mode_r.idle_fill && !mode_r.request_send) begin
      tx_val = TX_BIT | rts_n_r; // [RL14]
    end
    if (cfg1_r.open_drain) begin
      line_o  = 1'b0;
      line_oe = ~tx_val; // [RL13]
    end else begin
      line_o  = tx_val;
      line_oe = 1'b1; // [RL13]
    end
    txd_o_nxt  = line_o;
    txd_oe_nxt = line_oe;
    rxd_o_nxt  = 1'b0;
    rxd_oe_nxt = 1'b0;
    if (cfg2_r.serial_output_swap) begin
      txd_o_nxt  = 1'b0;
      txd_oe_nxt = 1'b0;
      rxd_o_nxt  = line_o; // [RL15]
      rxd_oe_nxt = line_oe; // [RL15]
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      rts_st_r <= RTS_IDLE;
      bus_tx_r <= 1'b0;
      rts_n_r  <= 1'b1;
      txd_o_r  <= 1'b1;
      txd_oe_r <= 1'b0;
      rxd_o_r  <= 1'b0;
      rxd_oe_r <= 1'b0;
    end else begin
      rts_st_r <= rts_st_nxt;
      bus_tx_r <= bus_tx_nxt;
      rts_n_r  <= rts_n_nxt;
      txd_o_r  <= txd_o_nxt;
      txd_oe_r <= txd_oe_nxt;
      rxd_o_r  <= rxd_o_nxt;
      rxd_oe_r <= rxd_oe_nxt;
    end
  end

  assign RTS_N_O    = rts_n_r;
  assign TXD_PIN_O  = txd_o_r;
  assign TXD_PIN_OE = txd_oe_r;
  assign RXD_PIN_O  = rxd_o_r;
  assign RXD_PIN_OE = rxd_oe_r;

  // ==========================================================
  // Receive path, carrier detect roles, enables
  logic mode1;
  logic mode5;
  logic use_xtal;

  assign mode1 = (cfg1_r.clock_mode == scmpl_pkg::CLK_MODE_1);
  assign mode5 = (cfg1_r.clock_mode == scmpl_pkg::CLK_MODE_5);

  // Receive data follows the swap as well
  assign RX_BIT = cfg2_r.serial_output_swap ? txd_pin_s
                                            : rxd_pin_s; // [RL18]

  // Tie CTS low to transmit permanently
  assign TX_ENABLE  = ~cts_s; // [RL6]
  assign CD_GENERAL = cd_s & ~mode1 & ~mode5; // [RL9]
  assign RX_ENABLE  = (!mode1 && !mode5 && cfg1_r.auto_start) ?
                      ~cd_s : 1'b1; // [RL9]
  assign RX_STROBE  = mode1 & ~cd_s; // [RL10]
  assign FRAME_SYNC = mode5 & cd_s; // [RL11]
  assign COLLISION  = coll_hit; // [RL8]

  // ==========================================================
  // Common crystal selection
  always_comb begin
    use_xtal = (cfg1_r.clock_mode == scmpl_pkg::CLK_MODE_4) ||
               (cfg1_r.clock_mode == scmpl_pkg::CLK_MODE_6) ||
               (cfg1_r.clock_mode == scmpl_pkg::CLK_MODE_7); // [RL16]
    if (SILICON_VERSION >= scmpl_pkg::VERSION_TWO) begin
      if ((cfg1_r.clock_mode == scmpl_pkg::CLK_MODE_0 && cfg1_r.sub_b) ||
          cfg1_r.master_clock) begin
        use_xtal = 1'b1; // [RL17]
      end
    end
  end

  assign COMMON_CLK_SEL = use_xtal;
  // Sampled crystal only; fine clocks need a real mux
  assign COMMON_CLK     = use_xtal & xtal_s;

endmodule : scmpl_top
`default_nettype wire

// ---- dv/scmpl_properties.sv ----
`timescale 1ns/10ps
`default_nettype none
module scmpl_properties (
  // Clock, reset and bus
  input wire logic        CLK,
  input wire logic        SYS_RST,
  input wire logic        WB_CYC_I,
  input wire logic        WB_STB_I,
  input wire logic        WB_WE_I,
  input wire logic [3:0]  WB_ADR_I,
  input wire logic [3:0]  WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic        WB_ACK_O,
  // Pins and engine side
  input wire logic        CLEAR_TO_SEND_IN,
  input wire logic        CARRIER_DETECT_IN,
  input wire logic        RTS_N_O,
  input wire logic        TXD_PIN_O,
  input wire logic        TXD_PIN_OE,
  input wire logic        TX_BIT,
  input wire logic        TX_BUSY,
  input wire logic        TX_PENDING,
  input wire logic        TX_ENABLE,
  input wire logic        RX_ENABLE,
  input wire logic        RX_STROBE,
  input wire logic        FRAME_SYNC,
  input wire logic        EVENT_IRQ
);
  // ==========================================================
  // Shadow of the configuration, so the checks know the mode
  logic       take;
  logic       wr;
  logic       st_rd;
  logic [8:0] c1_r;
  logic       sw_r;
  logic [1:0] age_r;
  assign take  = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  assign wr    = take && WB_WE_I && WB_SEL_I[0];
  assign st_rd = take && !WB_WE_I && WB_ADR_I == scmpl_pkg::ADDR_STATUS;
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      c1_r  <= 9'h000;
      sw_r  <= 1'b0;
      age_r <= 2'h0;
    end else begin
      // Synchronisers hold stale zeros just after reset
      if (age_r != 2'h3) age_r <= age_r + 2'h1;
      if (wr && WB_ADR_I == scmpl_pkg::ADDR_CFG1) c1_r[7:0] <= WB_DAT_I[7:0];
      if (take && WB_WE_I && WB_SEL_I[1] && WB_ADR_I == scmpl_pkg::ADDR_CFG1)
        c1_r[8] <= WB_DAT_I[8];
      if (wr && WB_ADR_I == scmpl_pkg::ADDR_CFG2) sw_r <= WB_DAT_I[0];
    end
  end
  // ==========================================================
  // Properties
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  chk_ack_next: assert property (take |=> WB_ACK_O)
    else $error("no ack one cycle after request");
  chk_rts_set: assert property (
    wr && !c1_r[5] && WB_ADR_I == scmpl_pkg::ADDR_MODE && WB_DAT_I[0]
    |-> ##[2:3] !RTS_N_O) else $error("request to send stayed high");
  chk_rts_hold: assert property (
    !c1_r[5] && !RTS_N_O && (TX_BUSY || TX_PENDING) |=> !RTS_N_O)
    else $error("request to send rose while transmitter busy");
  chk_tx_gate: assert property (
    age_r[1] |-> TX_ENABLE == !$past(CLEAR_TO_SEND_IN, 2))
    else $error("transmit enable does not follow clear to send");
  chk_cts_flag: assert property (
    age_r == 2'h3 && c1_r[6] && $changed(CLEAR_TO_SEND_IN)
    |-> ##[3:4] EVENT_IRQ) else $error("clear to send change not flagged");
  chk_cd_flag: assert property (
    age_r == 2'h3 && c1_r[7] && $changed(CARRIER_DETECT_IN)
    |-> ##[3:4] EVENT_IRQ) else $error("carrier change not flagged");
  chk_flag_stay: assert property (
    EVENT_IRQ && !st_rd |=> EVENT_IRQ) else $error("flag lost before read");
  chk_rx_strobe: assert property (
    age_r[1] && c1_r[2:0] == scmpl_pkg::CLK_MODE_1
    |-> RX_STROBE == !$past(CARRIER_DETECT_IN, 2))
    else $error("receive strobe wrong");
  chk_frame_sync: assert property (
    age_r[1] && c1_r[2:0] == scmpl_pkg::CLK_MODE_5
    |-> FRAME_SYNC == $past(CARRIER_DETECT_IN, 2))
    else $error("frame sync wrong");
  chk_rx_gate: assert property (
    age_r[1] && c1_r[4] && c1_r[2:0] != scmpl_pkg::CLK_MODE_1
    && c1_r[2:0] != scmpl_pkg::CLK_MODE_5
    |-> RX_ENABLE == !$past(CARRIER_DETECT_IN, 2))
    else $error("receiver enable wrong under auto start");
  chk_open_drain: assert property (
    age_r[1] && c1_r[8] && $past(c1_r[8]) && !sw_r && !$past(sw_r)
    |-> !TXD_PIN_O && TXD_PIN_OE == !$past(TX_BIT))
    else $error("open drain output wrong");
  chk_swap_pin: assert property (
    sw_r && $past(sw_r) |-> !TXD_PIN_OE) else $error("transmit pin driven");
  cover property (st_rd && EVENT_IRQ);
  cover property (c1_r[5] && !RTS_N_O);
  cover property (sw_r && TX_BIT);
endmodule : scmpl_properties
`default_nettype wire

// ---- dv/scmpl_line_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module scmpl_line_model (
  // Controls from the bench
  input  wire logic run,
  input  wire logic bus_mode,
  input  wire logic other_low,
  input  wire logic cts_n,
  input  wire logic cd_n,
  input  wire logic rx_data,
  // Device line pins
  input  wire logic txd_o,
  input  wire logic txd_oe,
  input  wire logic rxd_o,
  input  wire logic rxd_oe,
  // Wires seen by the device
  output var  logic bit_clk,
  output var  logic cts_pin,
  output var  logic cd_pin,
  output var  logic txd_pin,
  output var  logic rxd_pin
);
  logic line;
  // ==========================================================
  // Shared line with pull-up: any station at 0 wins
  assign line    = !((txd_oe && !txd_o) || other_low);
  assign cts_pin = bus_mode ? line : cts_n;
  assign cd_pin  = cd_n;
  assign txd_pin = line;
  assign rxd_pin = rxd_oe ? rxd_o : rx_data;
  // Bit clock stands still at zero while run is low
  initial bit_clk = 1'b0;
  always #32 bit_clk = run ? !bit_clk : 1'b0;
endmodule : scmpl_line_model
`default_nettype wire

// ---- dv/testbench.sv ----
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic        clk = 1'b0, rst = 1'b1, xtal = 1'b0;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
  logic [3:0]  adr = 4'h0, sel = 4'h0;
  logic [31:0] dat_i = 32'h0, dat_o, rdat;
  logic        cts_n = 1'b0, cd_n = 1'b1, cts_pin, cd_pin, rts_n, bclk;
  logic        txd_i, txd_o, txd_oe, rxd_i, rxd_o, rxd_oe, rx_bit;
  logic        tx_bit = 1'b0, tx_busy = 1'b0, tx_pend = 1'b0;
  logic        tx_frame = 1'b0, tx_coll = 1'b0, rx_frame = 1'b0;
  logic        run = 1'b0, bus_mode = 1'b0, other_low = 1'b0, rx_data = 1'b0;
  logic        tx_en, rx_en, rx_stb, fsync, cd_gen, coll, csel_o, cclk, irq;
  logic [1:0]  v, last;
  logic        hit;
  int          n_fail = 0, total_checks = 0;
  always #2 clk = !clk;
  // Toggles on falling clock edges so sampling never races
  always #12 xtal = !xtal;
  scmpl_top dut (
    .CLK(clk), .SYS_RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat_i), .WB_DAT_O(dat_o),
    .WB_ACK_O(ack), .CLEAR_TO_SEND_IN(cts_pin), .CARRIER_DETECT_IN(cd_pin),
    .RTS_N_O(rts_n), .TXD_PIN_I(txd_i), .TXD_PIN_O(txd_o),
    .TXD_PIN_OE(txd_oe), .RXD_PIN_I(rxd_i), .RXD_PIN_O(rxd_o),
    .RXD_PIN_OE(rxd_oe), .BIT_CLK_IN(bclk), .CRYSTAL_CLOCK_IN(xtal),
    .TX_BIT(tx_bit), .TX_BUSY(tx_busy), .TX_PENDING(tx_pend),
    .TX_FRAME(tx_frame), .TX_COLL_BIT(tx_coll), .RX_FRAME(rx_frame),
    .RX_BIT(rx_bit), .TX_ENABLE(tx_en), .RX_ENABLE(rx_en),
    .RX_STROBE(rx_stb), .FRAME_SYNC(fsync), .CD_GENERAL(cd_gen),
    .COLLISION(coll), .COMMON_CLK_SEL(csel_o), .COMMON_CLK(cclk),
    .EVENT_IRQ(irq));
  scmpl_line_model line (
    .run(run), .bus_mode(bus_mode), .other_low(other_low), .cts_n(cts_n),
    .cd_n(cd_n), .rx_data(rx_data), .txd_o(txd_o), .txd_oe(txd_oe),
    .rxd_o(rxd_o), .rxd_oe(rxd_oe), .bit_clk(bclk), .cts_pin(cts_pin),
    .cd_pin(cd_pin), .txd_pin(txd_i), .rxd_pin(rxd_i));
  // ==========================================================
  // Helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic ticks(input int n);
    repeat (n) @(posedge clk);
  endtask : ticks
  // One classic cycle; read data taken at the ack edge only
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_i <= d;
    sel <= 4'hF;
    do @(posedge clk); while (ack !== 1'b1);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb
  task automatic wait_rts(input logic lvl);
    for (int n = 0; n < 200 && rts_n !== lvl; n++) @(posedge clk);
    check(rts_n, lvl);
  endtask : wait_rts
  function automatic logic csel(input logic [2:0] md, input logic sb);
    return md inside {scmpl_pkg::CLK_MODE_4, scmpl_pkg::CLK_MODE_6,
                      scmpl_pkg::CLK_MODE_7} || (md == 3'h0 && sb);
  endfunction : csel
  task automatic test_done();
    if (n_fail == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : test_done
  initial begin
    repeat (40000) @(posedge clk);
    n_fail++;
    test_done();
  end
  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(32'hE23C75D2));
    ticks(2);
    rst <= 1'b0;
    wb(1'b0, scmpl_pkg::ADDR_STATUS, 32'h0);
    check(rdat[8:5], 4'h1);
    wb(1'b0, 4'h2, 32'h0);
    check(rdat, 32'h0);
    wb(1'b1, scmpl_pkg::ADDR_CFG1, 32'hC0);
    wb(1'b1, scmpl_pkg::ADDR_MODE, 32'h1);
    wait_rts(1'b0);
    tx_busy <= 1'b1;
    tx_pend <= 1'b1;
    wb(1'b1, scmpl_pkg::ADDR_MODE, 32'h0);
    tx_busy <= 1'b0;
    ticks(8);
    check(rts_n, 1'b0);
    tx_pend <= 1'b0;
    wait_rts(1'b1);
    last = 2'h2;
    for (int i = 0; i < 12; i++) begin
      v = 2'($urandom);
      cts_n <= v[0];
      cd_n <= v[1];
      rx_data <= v[0];
      ticks(6);
      check(tx_en, !v[0]);
      check(rx_bit, v[0]);
      check(irq, |(v ^ last));
      wb(1'b0, scmpl_pkg::ADDR_STATUS, 32'h0);
      check(rdat[1:0], v);
      check(rdat[8:7], v ^ last);
      wb(1'b0, scmpl_pkg::ADDR_STATUS, 32'h0);
      check(rdat[8:7], 2'h0);
      last = v;
    end
    for (int m = 0; m < 16; m++) begin
      wb(1'b1, scmpl_pkg::ADDR_CFG1, 32'(m | 16));
      cd_n <= 1'($urandom);
      ticks(4);
      check(csel_o, csel(m[2:0], m[3]));
      if (!csel(m[2:0], m[3])) check(cclk, 1'b0);
      if (m[2:0] == 3'h1) check(rx_stb, !cd_n);
      else if (m[2:0] == 3'h5) check(fsync, cd_n);
      else check({rx_en, cd_gen}, {!cd_n, cd_n});
    end
    wb(1'b1, scmpl_pkg::ADDR_CFG1, 32'h202);
    ticks(2);
    check(csel_o, 1'b1);
    // Common clock shows the crystal two samples late
    v = 2'h0;
    for (int i = 0; i < 14; i++) begin
      @(posedge clk);
      if (i > 1) check(cclk, v[1]);
      v = {v[0], xtal};
    end
    for (int od = 1; od >= 0; od--) begin
      wb(1'b1, scmpl_pkg::ADDR_CFG1, 32'(od << 8));
      for (int i = 0; i < 6; i++) begin
        tx_bit <= 1'($urandom);
        ticks(2);
        check({txd_o, txd_oe}, od ? {1'b0, !tx_bit} : {tx_bit, 1'b1});
      end
    end
    tx_bit <= 1'b0;
    wb(1'b1, scmpl_pkg::ADDR_MODE, 32'h6);
    ticks(3);
    check(txd_o, 1'b1);
    wb(1'b1, scmpl_pkg::ADDR_MODE, 32'h7);
    wait_rts(1'b0);
    ticks(2);
    check(txd_o, 1'b0);
    wb(1'b1, scmpl_pkg::ADDR_MODE, 32'h0);
    wb(1'b1, scmpl_pkg::ADDR_CFG2, 32'h1);
    for (int i = 0; i < 4; i++) begin
      other_low <= i[0];
      tx_bit <= i[1];
      ticks(4);
      check({txd_oe, rxd_oe, rxd_o}, {2'h1, i[1]});
      check(rx_bit, !i[0]);
    end
    other_low <= 1'b0;
    bus_mode <= 1'b1;
    wb(1'b1, scmpl_pkg::ADDR_CFG2, 32'h6);
    wb(1'b1, scmpl_pkg::ADDR_CFG1, 32'h20);
    wb(1'b1, scmpl_pkg::ADDR_MODE, 32'h1);
    rx_frame <= 1'b1;
    ticks(8);
    check(rts_n, 1'b1);
    wb(1'b1, scmpl_pkg::ADDR_MODE, 32'h0);
    wb(1'b1, scmpl_pkg::ADDR_CFG2, 32'h4);
    wait_rts(1'b0);
    rx_frame <= 1'b0;
    wait_rts(1'b1);
    wb(1'b1, scmpl_pkg::ADDR_CFG2, 32'h2);
    run <= 1'b1;
    tx_frame <= 1'b1;
    wait_rts(1'b0);
    tx_coll <= 1'b1;
    wait_rts(1'b1);
    tx_coll <= 1'b0;
    wb(1'b1, scmpl_pkg::ADDR_CFG1, 32'h120);
    for (int k = 1; k >= 0; k--) begin
      tx_bit <= 1'b1;
      other_low <= k[0];
      ticks(4);
      wb(1'b0, scmpl_pkg::ADDR_STATUS, 32'h0);
      hit = 1'b0;
      repeat (64) begin
        @(posedge clk);
        if (coll === 1'b1) hit = 1'b1;
      end
      check(hit, k[0]);
      wb(1'b0, scmpl_pkg::ADDR_STATUS, 32'h0);
      check(rdat[6], k[0]);
    end
    run <= 1'b0;
    test_done();
  end
endmodule : testbench
bind scmpl_top scmpl_properties chk (.*);
`default_nettype wire
